// File: core/lba_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
`include "lba_cfg.svh"
module lba_arbiter #(
	parameter int WS_W = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic system_reset_line_i,
	input wire logic [7:0] internal_config_register_i,
	input wire lba_pkg::lba_ws_s ws_cfg_i,
	input wire logic bus_req_i,
	input wire logic bus_done_i,
	input wire logic cyc_start_i,
	input wire lba_pkg::lba_cyc_e cyc_type_i,
	input wire logic cyc_read_i,
	input wire logic req_grant_line_a_i,
	input wire logic req_grant_line_b_i,
	output logic req_grant_line_a_o,
	output logic req_grant_line_a_oe_o,
	output logic req_grant_line_b_o,
	output logic req_grant_line_b_oe_o,
	output logic bus_owned_o,
	output logic bus_drive_o,
	output lba_pkg::lba_cmd_s cmd_o,
	output logic cyc_busy_o,
	output lba_pkg::lba_tstate_e tstate_o
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; lines are active low, idle pulled high
	logic [1:0] sys_rst_sync;
	logic [1:0] line_a_sync;
	logic [1:0] line_b_sync;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sys_rst_sync <= 2'h0;
			line_a_sync <= 2'h3;
			line_b_sync <= 2'h3;
		end else begin
			sys_rst_sync <= {sys_rst_sync[0], system_reset_line_i};
			line_a_sync <= {line_a_sync[0], req_grant_line_a_i};
			line_b_sync <= {line_b_sync[0], req_grant_line_b_i};
		end
	end
	// a released system reset line takes effect two clocks late
	logic active;
	assign active = sys_rst_sync[1];
	////////////////////////////////////////////////////////////////////////
	// line selection latched per exchange so a flag change mid-exchange cannot split it
	lba_pkg::lba_state_e state;
	logic use_b;
	logic grant_seen;
	assign grant_seen = use_b ? !line_b_sync[1] : !line_a_sync[1];
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			use_b <= 1'b0;
		end else if (state == lba_pkg::LBA_IDLE) begin
			// the flag is read only while idle
			use_b <= internal_config_register_i[`LBA_COPRO_BIT];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// exchange sequencer
	logic [1:0] cnt;
	logic pulse;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !active) begin
			state <= lba_pkg::LBA_IDLE;
			cnt <= 2'h0;
			pulse <= 1'b0;
		end else begin
			pulse <= 1'b0;
			unique case (state)
				lba_pkg::LBA_IDLE: begin
					if (bus_req_i) begin
						state <= lba_pkg::LBA_REQ;
						pulse <= 1'b1;
						cnt <= `LBA_ECHO_DLY;
					end
				end
				lba_pkg::LBA_REQ: begin
					// the line is shared, so our own pulse returns through the synchroniser
					// two clocks late and must not be taken for the grant
					if (cnt == 2'h0) begin
						state <= lba_pkg::LBA_WAIT_GT;
					end else begin
						cnt <= cnt - 2'h1;
					end
				end
				lba_pkg::LBA_WAIT_GT: begin
					// grant may come at T4 or idle of the processor; wait indefinitely
					// limitation: no timeout, a silent processor leaves the block waiting here
					if (grant_seen) begin
						state <= lba_pkg::LBA_HOLD;
						cnt <= `LBA_OWN_DLY;
					end
				end
				lba_pkg::LBA_HOLD: begin
					// processor floats the bus the clock after its grant
					if (cnt == 2'h1) begin
						state <= lba_pkg::LBA_OWN;
					end
					cnt <= cnt - 2'h1;
				end
				lba_pkg::LBA_OWN: begin
					if (bus_done_i) begin
						state <= lba_pkg::LBA_REL;
						pulse <= 1'b1;
					end
				end
				lba_pkg::LBA_REL: begin
					// one dead clock lets both sides resync before the next request
					state <= lba_pkg::LBA_DEAD;
					cnt <= `LBA_DEAD_CYC;
				end
				lba_pkg::LBA_DEAD: begin
					if (cnt == 2'h1) begin
						state <= lba_pkg::LBA_IDLE;
					end
					cnt <= cnt - 2'h1;
				end
				default: state <= lba_pkg::LBA_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// pin drive: only the selected line is ever enabled
	// lines are only pulled low; a released line reads the pull-up
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			req_grant_line_a_o <= 1'b1;
			req_grant_line_a_oe_o <= 1'b0;
			req_grant_line_b_o <= 1'b1;
			req_grant_line_b_oe_o <= 1'b0;
			bus_owned_o <= 1'b0;
			bus_drive_o <= 1'b0;
		end else begin
			req_grant_line_a_o <= 1'b0;
			req_grant_line_b_o <= 1'b0;
			req_grant_line_a_oe_o <= pulse && !use_b;
			req_grant_line_b_oe_o <= pulse && use_b;
			bus_owned_o <= (state == lba_pkg::LBA_OWN);
			// drive stops on the edge that raises the release pulse, a clock before the pulse reaches the line
			bus_drive_o <= (state == lba_pkg::LBA_OWN) && !bus_done_i;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// bus cycle timer on the system clock; I/O uses no slower channel clock
	function automatic logic [WS_W-1:0] ws_of(input lba_pkg::lba_cyc_e t,
			input lba_pkg::lba_ws_s w);
		unique case (t)
			lba_pkg::LBA_CYC_MEM: ws_of = WS_W'(w.mem_ws);
			lba_pkg::LBA_CYC_IO: ws_of = WS_W'(w.io_ws);
			default: ws_of = WS_W'(w.dma_ws);
		endcase
	endfunction : ws_of
	logic [WS_W-1:0] ws_left;
	logic rd_cyc;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !active) begin
			tstate_o <= lba_pkg::LBA_T1;
			ws_left <= WS_W'(`LBA_WS_RESET);
			rd_cyc <= 1'b0;
			cyc_busy_o <= 1'b0;
		end else begin
			unique case (tstate_o)
				lba_pkg::LBA_T1: begin
					if (cyc_start_i && !cyc_busy_o) begin
						cyc_busy_o <= 1'b1;
						rd_cyc <= cyc_read_i;
						ws_left <= ws_of(cyc_type_i, ws_cfg_i);
						tstate_o <= lba_pkg::LBA_T2;
					end else if (cyc_busy_o) begin
						cyc_busy_o <= 1'b0;
					end
				end
				lba_pkg::LBA_T2: tstate_o <= lba_pkg::LBA_T3;
				lba_pkg::LBA_T3: begin
					// a zero count skips the wait states
					tstate_o <= (ws_left == '0) ? lba_pkg::LBA_T4 : lba_pkg::LBA_TW;
				end
				lba_pkg::LBA_TW: begin
					ws_left <= ws_left - WS_W'(1);
					if (ws_left == WS_W'(1)) begin
						tstate_o <= lba_pkg::LBA_T4;
					end
				end
				lba_pkg::LBA_T4: tstate_o <= lba_pkg::LBA_T1;
				default: tstate_o <= lba_pkg::LBA_T1;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// commands delayed one state: asserted entering T3, dropped at T4
	// the window is judged one state ahead, so T3 with no waits already closes it
	logic cmd_win;
	assign cmd_win = (tstate_o == lba_pkg::LBA_T2)
		|| (tstate_o == lba_pkg::LBA_T3 && ws_left != '0)
		|| (tstate_o == lba_pkg::LBA_TW && ws_left != WS_W'(1));
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || !active) begin
			cmd_o <= '0;
		end else begin
			cmd_o.rd <= rd_cyc && cmd_win;
			cmd_o.wr <= !rd_cyc && cmd_win;
		end
	end
endmodule : lba_arbiter
`default_nettype wire

// File: core/lba_cfg.svh
`ifndef LBA_CFG_SVH
`define LBA_CFG_SVH
// bit position of the coprocessor-present flag in the internal config register
`define LBA_COPRO_BIT 1
// register address of that config byte, kept for reference by software models
`define LBA_CFG_ADDR 8'h43
// reset value of the wait-state counts
`define LBA_WS_RESET 4'h0
// dead clocks required after each exchange
`define LBA_DEAD_CYC 2'h1
// clocks between the grant and owning the bus
`define LBA_OWN_DLY 2'h1
// clocks the sequencer stays blind to the line after its own request pulse
`define LBA_ECHO_DLY 2'h3
`endif

// File: core/lba_pkg.sv
package lba_pkg;
	typedef enum logic [2:0] {
		LBA_IDLE = 3'b000,
		LBA_REQ = 3'b001,
		LBA_WAIT_GT = 3'b011,
		LBA_HOLD = 3'b010,
		LBA_OWN = 3'b110,
		LBA_REL = 3'b111,
		LBA_DEAD = 3'b101
	} lba_state_e;
	typedef enum logic [2:0] {
		LBA_T1 = 3'b000,
		LBA_T2 = 3'b001,
		LBA_T3 = 3'b011,
		LBA_TW = 3'b010,
		LBA_T4 = 3'b110
	} lba_tstate_e;
	typedef enum logic [1:0] {
		LBA_CYC_MEM = 2'h0,
		LBA_CYC_IO = 2'h1,
		LBA_CYC_DMA = 2'h2
	} lba_cyc_e;
	typedef struct packed {
		logic [3:0] mem_ws;
		logic [3:0] io_ws;
		logic [3:0] dma_ws;
	} lba_ws_s;
	typedef struct packed {
		logic rd;
		logic wr;
	} lba_cmd_s;
endpackage : lba_pkg

// File: test/lba_arbiter_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module lba_arbiter_monitor (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic system_reset_line_i,
	input wire logic bus_done_i,
	input wire logic req_grant_line_a_o,
	input wire logic req_grant_line_a_oe_o,
	input wire logic req_grant_line_b_o,
	input wire logic req_grant_line_b_oe_o,
	input wire logic bus_owned_o,
	input wire logic bus_drive_o,
	input wire lba_pkg::lba_cmd_s cmd_o,
	input wire logic cyc_busy_o,
	input wire lba_pkg::lba_tstate_e tstate_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_pulse_a: assert property (req_grant_line_a_oe_o |=> !req_grant_line_a_oe_o)
		else $error("line a pulse too wide");
	b_pulse_a: assert property (req_grant_line_b_oe_o |=> !req_grant_line_b_oe_o)
		else $error("line b pulse too wide");
	one_line_a: assert property (!(req_grant_line_a_oe_o && req_grant_line_b_oe_o))
		else $error("both lines driven");
	pulse_low_a: assert property ((req_grant_line_a_oe_o || req_grant_line_b_oe_o) |->
		!(req_grant_line_a_oe_o && req_grant_line_a_o) && !(req_grant_line_b_oe_o && req_grant_line_b_o))
		else $error("pulse not driven low");
	reset_idle_a: assert property (!system_reset_line_i [*4] |=> !bus_owned_o && !cmd_o)
		else $error("active while system reset low");
	cmd_late_a: assert property (cmd_o != 2'h0 |->
		tstate_o inside {lba_pkg::LBA_T3, lba_pkg::LBA_TW})
		else $error("command outside T3 and waits");
	t2_t3_a: assert property (tstate_o == lba_pkg::LBA_T2 |=> tstate_o == lba_pkg::LBA_T3)
		else $error("T2 not followed by T3");
	done_drop_a: assert property (bus_drive_o && bus_done_i |=> !bus_drive_o)
		else $error("bus still driven after done");
	drive_own_a: assert property (bus_drive_o |-> bus_owned_o)
		else $error("bus driven without ownership");
	busy_span_a: assert property (tstate_o != lba_pkg::LBA_T1 |-> cyc_busy_o)
		else $error("cycle busy low inside a bus cycle");
endmodule : lba_arbiter_monitor
`default_nettype wire

// File: test/lba_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// idle processor: grants each request after a chosen delay, no pull-down of its own otherwise
module lba_cpu_model (
	input wire logic clk_i,
	input wire logic [1:0] dev_low_i,
	input wire logic [3:0] dly_i,
	output logic [1:0] line_o
);
	logic [1:0] gnt = 2'h0;
	logic [3:0] cnt = 4'h0;
	logic pend = 1'b0;
	logic owned = 1'b0;
	logic sel = 1'b0;
	assign line_o = ~(dev_low_i | gnt); // pulled up when nobody drives
	always @(posedge clk_i) begin
		gnt <= 2'h0;
		if (!pend && !owned && dev_low_i != 2'h0) begin
			pend <= 1'b1;
			sel <= dev_low_i[1];
			cnt <= dly_i;
		end else if (pend && cnt == 4'h0) begin
			gnt[sel] <= 1'b1;
			pend <= 1'b0;
			owned <= 1'b1;
		end else if (pend) begin
			cnt <= cnt - 4'h1;
		end else if (owned && dev_low_i[sel]) begin
			owned <= 1'b0;
		end
	end
endmodule : lba_cpu_model
`default_nettype wire

// File: test/test_lba_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module test_lba_arbiter;
	logic ref_clk_i = 0, rst_n_i = 0, sys = 0, req = 0, done = 0, start = 0, rd = 0;
	logic [7:0] cfg = 8'h00;
	logic [3:0] dly = 4'h0;
	logic [1:0] line, dlow;
	lba_pkg::lba_ws_s ws = '0;
	lba_pkg::lba_cyc_e typ = lba_pkg::LBA_CYC_MEM;
	logic ao, aoe, bo, boe, own, drv, busy;
	lba_pkg::lba_cmd_s cmd;
	lba_pkg::lba_tstate_e ts;
	logic [7:0] q_line[$], q_len[$];
	logic [7:0] e;
	logic [11:0] f;
	lba_pkg::lba_cmd_s c_seen = '0;
	logic [7:0] n = 0, last = 0;
	logic pown = 0;
	int err_count = 0, total_checks = 0, seed = 32'h851e, tick = 0, k;
	always #4 ref_clk_i = ~ref_clk_i;
	assign dlow = {boe & ~bo, aoe & ~ao};
	lba_cpu_model cpu (.clk_i(ref_clk_i), .dev_low_i(dlow), .dly_i(dly), .line_o(line));
	lba_arbiter DUT (.ref_clk_i, .rst_n_i, .system_reset_line_i(sys),
		.internal_config_register_i(cfg), .ws_cfg_i(ws), .bus_req_i(req), .bus_done_i(done),
		.cyc_start_i(start), .cyc_type_i(typ), .cyc_read_i(rd), .req_grant_line_a_i(line[0]),
		.req_grant_line_b_i(line[1]), .req_grant_line_a_o(ao), .req_grant_line_a_oe_o(aoe),
		.req_grant_line_b_o(bo), .req_grant_line_b_oe_o(boe), .bus_owned_o(own),
		.bus_drive_o(drv), .cmd_o(cmd), .cyc_busy_o(busy), .tstate_o(ts));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk_line(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected line at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_line
	task automatic chk_len(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected strobe at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_len
	task automatic chk_own(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected ownership at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_own
	////////////////////////////////////////////////////////////////////////////////
	// watcher: pulse line seen before ownership, and command width per cycle
	always @(posedge ref_clk_i) begin
		tick++;
		// ceiling far above the roughly 300 cycles the scenarios need
		if (tick > 20000) begin
			err_count++;
			end_sim();
		end else begin
			if (aoe | boe) last = {6'h0, boe, aoe};
			if (own && !pown) begin
				e = (q_line.size() != 0) ? q_line.pop_front() : 8'hFF;
				chk_line(last, e);
			end
			pown = own;
			if (cmd != 2'h0) begin
				n++;
				c_seen = cmd;
			end else if (n != 0) begin
				e = (q_len.size() != 0) ? q_len.pop_front() : 8'hFF;
				chk_len({c_seen, n[5:0]}, e);
				n = 0;
			end
		end
	end
	task automatic wt(input logic v);
		for (k = 0; k < 200 && own !== v; k++) @(posedge ref_clk_i);
		chk_own({7'h0, own}, {7'h0, v});
	endtask : wt
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1;
		repeat (6) @(posedge ref_clk_i);
		// a real board holds the line low far longer; the block only needs it synced
		sys <= 1;
		repeat (4) @(posedge ref_clk_i);
		for (int i = 0; i < 4; i++) begin
			cfg <= 8'h02 * i[0];
			dly <= 4'({$random(seed)} % 6);
			q_line.push_back(i[0] ? 8'h02 : 8'h01);
			req <= 1;
			wt(1);
			req <= 0;
			repeat (3) @(posedge ref_clk_i);
			done <= 1;
			@(posedge ref_clk_i);
			done <= 0;
			wt(0);
			repeat (3) @(posedge ref_clk_i);
		end
		$display("ownership test done");
		for (int i = 0; i < 6; i++) begin
			ws <= 12'($random(seed)) & 12'h333;
			typ <= lba_pkg::lba_cyc_e'(i % 3);
			rd <= 1'($random(seed));
			@(posedge ref_clk_i);
			f = ws >> (4 * (2 - i % 3));
			q_len.push_back({rd, !rd, 2'h0, f[3:0] + 4'h1});
			start <= 1;
			@(posedge ref_clk_i);
			start <= 0;
			repeat (30) @(posedge ref_clk_i);
		end
		$display("wait state test done");
		// drop the system reset line mid-cycle: the strobe stands from its T2 edge
		// until two sync flops and the forcing edge have passed
		ws <= 12'hFFF;
		typ <= lba_pkg::LBA_CYC_MEM;
		rd <= 1'($random(seed));
		@(posedge ref_clk_i);
		q_len.push_back({rd, !rd, 6'h03});
		start <= 1;
		@(posedge ref_clk_i);
		start <= 0;
		@(posedge ref_clk_i);
		sys <= 0;
		repeat (6) @(posedge ref_clk_i);
		sys <= 1;
		repeat (6) @(posedge ref_clk_i);
		$display("system reset test done");
		end_sim();
	end
endmodule : test_lba_arbiter
bind lba_arbiter lba_arbiter_monitor u_mon (.ref_clk_i, .rst_n_i, .system_reset_line_i,
	.bus_done_i, .req_grant_line_a_o, .req_grant_line_a_oe_o, .req_grant_line_b_o,
	.req_grant_line_b_oe_o, .bus_owned_o, .bus_drive_o, .cmd_o, .cyc_busy_o, .tstate_o);
`default_nettype wire
